/* File: srp_regs.sv */
// Per-synthesizer frequency ratio and initial phase configuration bank
`timescale 1ns/100ps
`include "srp_map.svh"
module srp_regs
    import srp_pkg::*;
(
    input  wire logic                      i_clock,               // 50 MHz clock
    input  wire logic                      i_reset_n,             // Async reset, active low
    input  wire logic [15:0]               i_addr,                // Byte address
    input  wire logic                      i_wr,                  // Byte write strobe
    input  wire logic                      i_rd,                  // Byte read strobe
    input  wire logic [7:0]                i_wdata,               // Write byte
    input  wire logic                      i_from_flash,          // Write comes from flash load
    output logic      [7:0]                o_rdata,               // Read byte, next cycle
    output logic                           o_rvalid,              // Read byte valid pulse
    input  wire logic                      i_mailbox_write,       // Mailbox write request pulse
    input  wire logic [`SRP_NUM_SYNTHS-1:0] i_mailbox_target_mask, // Synths to update
    output logic                           o_mailbox_done,        // Apply finished pulse
    input  wire logic [15:0]               i_base_frequency_term, // Base frequency in Hz
    input  wire logic [`SRP_NUM_SYNTHS-1:0] i_synth_start,         // Synth switch-on pulses
    input  wire logic [`SRP_SEL_W-1:0]     i_view_sel,            // Synth shown on view outputs
    output srp_freq_t                      o_freq_hz,             // Frequency of viewed synth
    output srp_phase_t                     o_start_phase,         // Phase latched at last start
    output logic [`SRP_NUM_SYNTHS-1:0]     o_phase_offset_present // Extra offset active
);
    srp_cfg_s                        page_r;
    logic                            page_arm_r;
    srp_cfg_s                        synth_r [`SRP_NUM_SYNTHS];
    srp_phase_t                      start_phase_r [`SRP_NUM_SYNTHS];
    logic [`SRP_NUM_SYNTHS-1:0]      offset_r;
    logic [`SRP_NUM_SYNTHS-1:0]      offset_nxt;
    logic [7:0]                      rd_byte;
    logic [3:0]                      addr_lane;
    logic                            host_phase_nz;
    logic [`SRP_NUM_SYNTHS-1:0]      apply;
    srp_cfg_s                        view_cfg;
    logic [63:0]                     product;
    srp_freq_t                       freq_nxt;
    srp_phase_t                      phase_nxt;

    // Byte lane 0..9 of the page for an address, F when unmapped
    function automatic logic [3:0] byte_lane(input logic [15:0] a);
        logic [15:0] rel;
        rel = a - `SRP_MULT_ADDR;
        if (a < `SRP_MULT_ADDR || a > `SRP_LAST_ADDR) begin
            rel = 16'h000F;
        end
        return rel[3:0];
    endfunction

    // Byte of the page at a lane; lowest address holds the top byte
    function automatic logic [7:0] page_byte(input srp_cfg_s c, input logic [3:0] lane);
        logic [7:0] b;
        b = 8'h00;
        case (lane)
            4'h0:    b = c.mult[31:24];
            4'h1:    b = c.mult[23:16];
            4'h2:    b = c.mult[15:8];
            4'h3:    b = c.mult[7:0];
            4'h4:    b = c.num[15:8];
            4'h5:    b = c.num[7:0];
            4'h6:    b = c.div[15:8];
            4'h7:    b = c.div[7:0];
            4'h8:    b = c.phase[15:8];
            4'h9:    b = c.phase[7:0];
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // Page (staging) registers written by the host or a flash load, one byte at a time
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            page_r.mult  <= `SRP_MULT_RESET;
            page_r.num   <= `SRP_NUM_RESET;
            page_r.div   <= `SRP_DIV_RESET;
            page_r.phase <= `SRP_PHASE_RESET;
        end else if (i_wr) begin
            case (addr_lane)
                4'h0:    page_r.mult[31:24] <= i_wdata;
                4'h1:    page_r.mult[23:16] <= i_wdata;
                4'h2:    page_r.mult[15:8]  <= i_wdata;
                4'h3:    page_r.mult[7:0]   <= i_wdata;
                4'h4:    page_r.num[15:8]   <= i_wdata;
                4'h5:    page_r.num[7:0]    <= i_wdata;
                4'h6:    page_r.div[15:8]   <= i_wdata;
                4'h7:    page_r.div[7:0]    <= i_wdata;
                4'h8:    page_r.phase[15:8] <= i_wdata;
                4'h9:    page_r.phase[7:0]  <= i_wdata;
                default: ;
            endcase
        end
    end

    // Host write of a non-zero phase byte; flash loads are excluded
    assign host_phase_nz = i_wr && !i_from_flash && (i_wdata != 8'h00)
                           && (i_addr == `SRP_PHASE_ADDR || i_addr == `SRP_LAST_ADDR);

    // Marks a host write of a non-zero phase byte; flash loads never arm it
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            page_arm_r <= 1'b0;
        end else if (host_phase_nz) begin
            page_arm_r <= 1'b1;
        end
    end

    // Read path: one-cycle latency, unmapped addresses read zero
    assign addr_lane = byte_lane(i_addr);
    assign rd_byte   = page_byte(page_r, addr_lane);

    // Valid is a one-cycle echo of the read strobe
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rvalid <= 1'b0;
        end else begin
            o_rvalid <= i_rd;
        end
    end

    // Data holds between reads so a slow host can still pick it up
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rd_byte;
        end
    end

    // One apply strobe per synth, shared by the copy and the offset flag
    assign apply = i_mailbox_write ? i_mailbox_target_mask : '0;

    // Mailbox apply: whole page copied in one cycle, so done follows at once
    generate
        for (genvar s = 0; s < `SRP_NUM_SYNTHS; s++) begin : g_synth
            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    synth_r[s].mult  <= `SRP_MULT_RESET;
                    synth_r[s].num   <= `SRP_NUM_RESET;
                    synth_r[s].div   <= `SRP_DIV_RESET;
                    synth_r[s].phase <= `SRP_PHASE_RESET;
                end else if (apply[s]) begin
                    synth_r[s] <= page_r;
                end
            end

            // Phase sampled only at switch-on; later edits wait for next start
            always_ff @(posedge i_clock or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    start_phase_r[s] <= `SRP_PHASE_RESET;
                end else if (i_synth_start[s]) begin
                    start_phase_r[s] <= synth_r[s].phase;
                end
            end

            assign offset_nxt[s] = offset_r[s]
                | (apply[s] && page_arm_r);
        end
    endgenerate

    // Sticky until reset: the offset never goes away by itself
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            offset_r <= '0;
        end else begin
            offset_r <= offset_nxt;
        end
    end

    assign o_phase_offset_present = offset_r;

    // Done stands in for the write bit reading back clear
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_mailbox_done <= 1'b0;
        end else begin
            o_mailbox_done <= i_mailbox_write;
        end
    end

    // Frequency of the viewed synth; a zero divisor shows zero, not garbage
    always_comb begin
        view_cfg  = (i_view_sel < `SRP_NUM_SYNTHS) ? synth_r[i_view_sel] : '0;
        product   = 64'(i_base_frequency_term) * 64'(view_cfg.mult) * 64'(view_cfg.num);
        freq_nxt  = 64'h0000000000000000;
        phase_nxt = `SRP_PHASE_RESET;
        if (view_cfg.div != 16'h0000) begin
            freq_nxt = product / 64'(view_cfg.div);
        end
        if (i_view_sel < `SRP_NUM_SYNTHS) begin
            phase_nxt = start_phase_r[i_view_sel];
        end
    end

    // Divider output is registered to keep the long path off the ports
    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_freq_hz <= 64'h0000000000000000;
        end else begin
            o_freq_hz <= freq_nxt;
        end
    end

    always_ff @(posedge i_clock or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_start_phase <= `SRP_PHASE_RESET;
        end else begin
            o_start_phase <= phase_nxt;
        end
    end
endmodule // srp_regs

/* File: srp_map.svh */
// Offsets, reset values and sizes of the synthesizer ratio and phase bank
`ifndef SRP_MAP_SVH
`define SRP_MAP_SVH
`define SRP_MULT_ADDR   16'h0688
`define SRP_NUM_ADDR    16'h068C
`define SRP_DIV_ADDR    16'h068E
`define SRP_PHASE_ADDR  16'h0690
`define SRP_LAST_ADDR   16'h0691
`define SRP_MULT_RESET  32'h12A05F20
`define SRP_NUM_RESET   16'h0001
`define SRP_DIV_RESET   16'h0001
`define SRP_PHASE_RESET 16'h0000
`define SRP_NUM_SYNTHS  5
`define SRP_SEL_W       3
`endif

/* File: srp_pkg.sv */
// Types shared by the synthesizer ratio and phase bank
`include "srp_map.svh"
package srp_pkg;
    typedef logic [31:0]        srp_mult_t;
    typedef logic [15:0]        srp_term_t;
    typedef logic signed [15:0] srp_phase_t;
    typedef logic [63:0]        srp_freq_t;
    typedef struct packed {
        srp_mult_t  mult;
        srp_term_t  num;
        srp_term_t  div;
        srp_phase_t phase;
    } srp_cfg_s;
endpackage

/* File: srp_regs_asserts.sv */
// Port-level timing checks for the synthesizer ratio and phase bank
`timescale 1ns/100ps
`include "srp_map.svh"
module srp_regs_asserts
    import srp_pkg::*;
(
    input wire logic                       i_clock,               // Clock
    input wire logic                       i_reset_n,             // Reset
    input wire logic                       i_rd,                  // Read
    input wire logic                       o_rvalid,              // Read valid
    input wire logic                       i_mailbox_write,       // Apply
    input wire logic                       o_mailbox_done,        // Applied
    input wire logic [`SRP_SEL_W-1:0]      i_view_sel,            // View
    input wire logic [15:0]                i_base_frequency_term, // Base
    input wire logic [`SRP_NUM_SYNTHS-1:0] i_synth_start,         // Starts
    input wire srp_freq_t                  o_freq_hz,             // Frequency
    input wire srp_phase_t                 o_start_phase,         // Phase
    input wire logic [`SRP_NUM_SYNTHS-1:0] o_phase_offset_present // Offsets
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);
    // Latch then view register gives two stages
    sequence s_quiet_start;
        i_synth_start == 0 ##1 $stable(i_view_sel);
    endsequence
    sequence s_quiet_cfg;
        !i_mailbox_write ##1 ($stable(i_view_sel) && $stable(i_base_frequency_term));
    endsequence
    AST_RD_ANSWER: assert property (i_rd |=> o_rvalid)
        else $error("read not answered");
    AST_RD_ONLY: assert property (!i_rd |=> !o_rvalid)
        else $error("spurious read valid");
    AST_MB_DONE: assert property (i_mailbox_write |=> o_mailbox_done)
        else $error("apply not acknowledged");
    AST_MB_ONLY: assert property (!i_mailbox_write |=> !o_mailbox_done)
        else $error("spurious apply done");
    AST_OFS_STICKY: assert property (1 |=> ($past(o_phase_offset_present) & ~o_phase_offset_present) == 0)
        else $error("offset flag dropped");
    AST_OFS_MB: assert property (!i_mailbox_write |=> $stable(o_phase_offset_present))
        else $error("offset flag changed without apply");
    AST_START_HOLD: assert property (s_quiet_start |=> $stable(o_start_phase))
        else $error("start phase changed without start");
    AST_FREQ_HOLD: assert property (s_quiet_cfg |=> $stable(o_freq_hz))
        else $error("frequency changed without cause");
    AST_VIEW_OFF: assert property (i_view_sel >= 3'h5 |=> o_freq_hz == 64'h0 && o_start_phase == 16'sh0)
        else $error("unused view not zero");
endmodule // srp_regs_asserts

/* File: test_srp_regs.sv */
// Self-checking bench for the synthesizer ratio and phase bank
`timescale 1ns/100ps
`include "srp_map.svh"
module test_srp_regs;
    import srp_pkg::*;
    logic             i_clock, i_reset_n, i_wr, i_rd, i_from_flash, i_mailbox_write;
    logic             o_rvalid, o_mailbox_done, fl, armed;
    logic [15:0]      i_addr, i_base_frequency_term;
    logic [7:0]       i_wdata, o_rdata, wd, pg [10];
    logic [4:0]       i_mailbox_target_mask, i_synth_start, o_phase_offset_present, offs;
    logic [2:0]       i_view_sel;
    logic [63:0]      km [5], nm [5], dm [5];
    srp_freq_t        o_freq_hz;
    srp_phase_t       o_start_phase, ph [5], sp [5];
    int               fail_count, comparisons;
    srp_regs dut_u (.*);
    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge i_clock);
        i_rd <= 0; i_wr <= 1; i_addr <= 16'(a); i_wdata <= d; i_from_flash <= fl;
        if (a >= 16'h0688 && a <= 16'h0691) pg[a - 16'h0688] = d;
        if (!fl && a >= 16'h0690 && a <= 16'h0691 && d != 0) armed = 1; // Flash loads never arm
    endtask
    task automatic rd(input int a);
        @(posedge i_clock);
        i_wr <= 0; i_rd <= 1; i_addr <= 16'(a);
        @(posedge i_clock);
        i_rd <= 0;
        #1 cmp(o_rvalid, 1);
        cmp(o_rdata, (a >= 16'h0688 && a <= 16'h0691) ? pg[a - 16'h0688] : 8'h00);
    endtask
    task automatic mb(input logic [4:0] m);
        @(posedge i_clock);
        i_wr <= 0; i_mailbox_write <= 1; i_mailbox_target_mask <= m;
        for (int s = 0; s < 5; s++) if (m[s]) begin
            km[s] = {pg[0], pg[1], pg[2], pg[3]}; nm[s] = {pg[4], pg[5]};
            dm[s] = {pg[6], pg[7]}; ph[s] = {pg[8], pg[9]};
        end
        if (armed) offs |= m;
        @(posedge i_clock);
        i_mailbox_write <= 0;
        #1 cmp(o_mailbox_done, 1);
    endtask
    task automatic view(input int s);
        logic [63:0] f;
        @(posedge i_clock);
        i_view_sel <= 3'(s);
        repeat (2) @(posedge i_clock);
        f = (s < 5 && dm[s] != 0) ? i_base_frequency_term * km[s] * nm[s] / dm[s] : 64'h0;
        #1 cmp(o_freq_hz, f);
        if (s < 5) cmp(o_start_phase, sp[s]);
        else cmp(o_start_phase, 64'h0);
    endtask
    task automatic results();
        if (fail_count == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        i_clock = 0;
        forever #10 i_clock = ~i_clock;
    end
    initial begin
        #200000 fail_count++;
        results();
    end
    initial begin
        {i_reset_n, i_wr, i_rd, i_from_flash, i_mailbox_write, i_addr, i_wdata} = 0;
        {i_mailbox_target_mask, i_synth_start, i_view_sel, fl, armed, offs} = 0;
        i_base_frequency_term = 16'h0001;
        pg = '{8'h12, 8'hA0, 8'h5F, 8'h20, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00, 8'h00};
        for (int s = 0; s < 5; s++) begin
            km[s] = `SRP_MULT_RESET; nm[s] = 1; dm[s] = 1; ph[s] = 0; sp[s] = 0;
        end
        void'($urandom(75586));
        repeat (5) @(posedge i_clock);
        i_reset_n <= 1;
        view(0);
        for (int it = 0; it < 6; it++) begin
            for (int a = 16'h0687; a <= 16'h0692; a++) rd(a);
            fl = (it < 2) || (it > 2 && 1'($urandom)); // Pass 2 is always a host write
            for (int a = 16'h0687; a <= 16'h0692; a++) begin
                wd = (it == 4 && (a == 16'h068E || a == 16'h068F)) ? 8'h00 : 8'($urandom);
                wr(a, wd);
            end
            mb(5'($urandom) | 5'(1 << (it % 5)));
            @(posedge i_clock);
            i_synth_start <= 5'(1 << (it % 5));
            sp[it % 5] = ph[it % 5];
            @(posedge i_clock);
            i_synth_start <= 0;
            i_base_frequency_term <= 16'($urandom);
            for (int s = 0; s < 8; s++) view(s);
            cmp(o_phase_offset_present, offs);
        end
        results();
    end
endmodule // test_srp_regs
bind srp_regs srp_regs_asserts chk_u (.*);
